// ===== hw/sar_adc_seq_cfg.svh
// Purpose: constants for the sar converter sequencer
// Assumes: core clock of 125 MHz
// Notes:   all counts derive from the figures below
`ifndef SAR_ADC_SEQ_CFG_SVH
`define SAR_ADC_SEQ_CFG_SVH
// ==========================================================
// clocking
`define CORE_CLK_KHZ    125000
`define ADC_CLK_MAX_KHZ 14500
// smallest integer divide keeping the converter clock legal
`define ADC_DIV ((`CORE_CLK_KHZ + `ADC_CLK_MAX_KHZ - 1) / `ADC_CLK_MAX_KHZ)
// ==========================================================
// conversion
`define SAR_BITS      12
`define CONV_MIN_CLKS 18
`define SAMPLE_MIN    (`CONV_MIN_CLKS - `SAR_BITS)
`define SAR_MSB       12'h800
`define NUM_CHAN      8
`define TEMP_CHAN     3'h7
// ==========================================================
// reference select encodings
`define REF_VDD     2'h0
`define REF_VDD_HALF 2'h1
`define REF_BANDGAP 2'h2
`define REF_EXT     2'h3
`endif

// ===== hw/sar_adc_seq_pkg.sv
// Purpose: types for the sar converter sequencer
// Assumes: nothing
// Notes:   constants live in the cfg header
package sar_adc_seq_pkg;
  // ========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } state_t;
endpackage

// ===== hw/sar_adc_sequencer_control.sv
// Purpose: sar converter control with an 8-channel sequencer
// Assumes: compIn comes from the analog comparator, unsynchronised
// Notes:   one conversion at a time; requests launch on a tick
//
// How it works
// - converter tick is core clock divided by 9, under 14.5 MHz
// - a conversion spans sample ticks plus 12 bit ticks, at least 18
// - chanSel routes one of eight channels, picked from the enable set when scanning, from fwChan in fwMode
// - scan steps through every enabled channel once, no software
// - next channel starts sampling on the same tick the last ends
// - fwMode chooses firmware channel picks over the hardware scanner
// - each channel keeps its own result register and valid flag
// - each channel has its own sample time input
// - low and high limits are inputs checked against every result
// - out-of-range flag rises on the result tick, mid scan
// - refSel offers supply, half supply, bandgap or external pin
// - acquisition length is programmable to suit slow drivers
// - tempOnCh7 routes the temperature sensor onto channel 7
// - lowPower forces idle; nothing converts without the clock
`include "sar_adc_seq_cfg.svh"

module sar_adc_sequencer_control (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             lowPower,
  input  wire logic             fwMode,
  input  wire logic             fwStart,
  input  wire logic [2:0]       fwChan,
  input  wire logic             scanStart,
  input  wire logic             scanCont,
  input  wire logic [7:0]       chanEnable,
  input  wire logic [7:0][7:0]  sampleTime,
  input  wire logic             tempOnCh7,
  input  wire logic [1:0]       refSelect,
  input  wire logic [11:0]      rangeLow,
  input  wire logic [11:0]      rangeHigh,
  input  wire logic [7:0]       resultClr,
  input  wire logic             rangeClr,
  input  wire logic             compIn,
  output logic      [11:0]      sarTrial,
  output logic                  sampling,
  output logic                  busy,
  output logic      [2:0]       chanSel,
  output logic                  tempSensEn,
  output logic      [1:0]       refSel,
  output logic                  extRefEn,
  output logic      [7:0][11:0] result,
  output logic      [7:0]       resultValid,
  output logic      [7:0]       rangeFlag,
  output logic                  rangeIrq,
  output logic                  scanDone
);
  // ========================================================
  // helpers
  // next enabled channel above cur, wrapping; cur if none
  function automatic logic [2:0] firstAfter(input logic [7:0] en,
                                            input logic [2:0] cur);
    logic [2:0] idx;
    logic       found;
    firstAfter = cur;
    found = 1'b0;
    for (int i = 1; i <= `NUM_CHAN; i++) begin
      idx = cur + i[2:0];
      if (en[idx] && !found) begin
        firstAfter = idx;
        found = 1'b1;
      end
    end
  endfunction
  // sample ticks, floored so a conversion never drops below 18
  function automatic logic [7:0] sampLen(input logic [7:0] t);
    sampLen = (t < 8'(`SAMPLE_MIN)) ? 8'(`SAMPLE_MIN) : t;
  endfunction

  sar_adc_seq_pkg::state_t state_ff;
  logic [3:0]  divCnt_ff;
  logic        adcTick_ff, compMeta_ff, compSync_ff, pend_ff;
  logic [2:0]  curChan_ff;
  logic [7:0]  sampCnt_ff;
  logic [3:0]  bitIdx_ff;
  logic [11:0] sarTrial_ff;
  logic        rangeIrq_ff, scanDone_ff, tempSensEn_ff, extRefEn_ff;
  logic [1:0]  refSel_ff;
  logic [2:0]  nxtChan, lowestChan, launchChan;
  logic        lastOfScan, launch, resultStb, outRange;
  logic [11:0] bitMask, finalCode;
  // ========================================================
  // converter clock enable
  // divide keeps the sar engine under its clock limit; sleep parks it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_ff  <= 4'h0;
      adcTick_ff <= 1'b0;
    end else if (lowPower || divCnt_ff == 4'(`ADC_DIV - 1)) begin
      divCnt_ff  <= 4'h0;
      adcTick_ff <= !lowPower;
    end else begin
      divCnt_ff  <= divCnt_ff + 4'h1;
      adcTick_ff <= 1'b0;
    end
  end
  // comparator synchroniser, second stage only is read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      compMeta_ff <= 1'b0;
      compSync_ff <= 1'b0;
    end else begin
      compMeta_ff <= compIn;
      compSync_ff <= compMeta_ff;
    end
  end
  // ========================================================
  // channel choice
  always_comb begin
    nxtChan    = firstAfter(chanEnable, curChan_ff);
    lowestChan = firstAfter(chanEnable, 3'h7);
    lastOfScan = (nxtChan <= curChan_ff);
    launchChan = fwMode ? fwChan : lowestChan;
    launch     = (state_ff == sar_adc_seq_pkg::ST_IDLE) && pend_ff &&
                 adcTick_ff && (fwMode || (|chanEnable));
    resultStb  = adcTick_ff && (bitIdx_ff == 4'h0) &&
                 (state_ff == sar_adc_seq_pkg::ST_CONVERT);
  end
  // start request waits for a tick so sampling is whole periods;
  // a new request beats the launch clear so none is lost
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= !lowPower &&
                 ((fwMode ? fwStart : scanStart) || (pend_ff && !launch));
    end
  end
  // ========================================================
  // sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff   <= sar_adc_seq_pkg::ST_IDLE;
      curChan_ff <= 3'h0;
      sampCnt_ff <= 8'h00;
      bitIdx_ff  <= 4'h0;
    end else if (lowPower) begin
      state_ff   <= sar_adc_seq_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        sar_adc_seq_pkg::ST_IDLE: begin
          if (launch) begin
            state_ff   <= sar_adc_seq_pkg::ST_SAMPLE;
            curChan_ff <= launchChan;
            sampCnt_ff <= sampLen(sampleTime[launchChan]);
          end
        end
        sar_adc_seq_pkg::ST_SAMPLE: begin
          if (adcTick_ff) begin
            if (sampCnt_ff <= 8'h01) begin
              state_ff  <= sar_adc_seq_pkg::ST_CONVERT;
              bitIdx_ff <= 4'(`SAR_BITS - 1);
            end else begin
              sampCnt_ff <= sampCnt_ff - 8'h01;
            end
          end
        end
        sar_adc_seq_pkg::ST_CONVERT: begin
          if (resultStb) begin
            // no idle tick between channels
            if (!fwMode && !lastOfScan) begin
              state_ff   <= sar_adc_seq_pkg::ST_SAMPLE;
              curChan_ff <= nxtChan;
              sampCnt_ff <= sampLen(sampleTime[nxtChan]);
            end else if (!fwMode && scanCont && (|chanEnable)) begin
              state_ff   <= sar_adc_seq_pkg::ST_SAMPLE;
              curChan_ff <= lowestChan;
              sampCnt_ff <= sampLen(sampleTime[lowestChan]);
            end else begin
              state_ff <= sar_adc_seq_pkg::ST_IDLE;
            end
          end else if (adcTick_ff) begin
            bitIdx_ff <= bitIdx_ff - 4'h1;
          end
        end
        default: state_ff <= sar_adc_seq_pkg::ST_IDLE;
      endcase
    end
  end
  // ========================================================
  // successive approximation
  always_comb begin
    bitMask   = 12'h001 << bitIdx_ff;
    finalCode = (sarTrial_ff & ~bitMask) | (compSync_ff ? bitMask : 12'h000);
    outRange  = (finalCode < rangeLow) || (finalCode > rangeHigh);
  end

  // comparator high keeps the trial bit; next bit then goes up
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sarTrial_ff <= `SAR_MSB;
    end else if (state_ff != sar_adc_seq_pkg::ST_CONVERT) begin
      sarTrial_ff <= `SAR_MSB;
    end else if (resultStb) begin
      sarTrial_ff <= `SAR_MSB;
    end else if (adcTick_ff) begin
      sarTrial_ff <= finalCode | (bitMask >> 1);
    end
  end
  // ========================================================
  // per-channel results, set wins over a same-cycle clear
  // registers live in each slice so every one has a single driver
  for (genvar g = 0; g < `NUM_CHAN; g++) begin : g_res
    logic        hit;
    logic [11:0] res_ff;
    logic        valid_ff;
    logic        flag_ff;
    assign hit = resultStb && (curChan_ff == 3'(g));
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        res_ff   <= 12'h000;
        valid_ff <= 1'b0;
        flag_ff  <= 1'b0;
      end else begin
        if (hit) begin
          res_ff <= finalCode;
        end
        valid_ff <= hit || (valid_ff && !resultClr[g]);
        flag_ff  <= (hit && outRange) || (flag_ff && !resultClr[g]);
      end
    end
    assign result[g]      = res_ff;
    assign resultValid[g] = valid_ff;
    assign rangeFlag[g]   = flag_ff;
  end

  // out-of-range request rises at once, not at scan end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rangeIrq_ff <= 1'b0;
    end else begin
      rangeIrq_ff <= (resultStb && outRange) ||
                     (rangeIrq_ff && !rangeClr);
    end
  end

  // end of scan or of a firmware conversion
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scanDone_ff <= 1'b0;
    end else begin
      scanDone_ff <= resultStb && (fwMode || lastOfScan);
    end
  end
  // ========================================================
  // analog side controls
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      refSel_ff     <= `REF_VDD;
      extRefEn_ff   <= 1'b0;
      tempSensEn_ff <= 1'b0;
    end else begin
      refSel_ff     <= refSelect;
      extRefEn_ff   <= (refSelect == `REF_EXT);
      tempSensEn_ff <= tempOnCh7 && (curChan_ff == `TEMP_CHAN) &&
                       !lowPower;
    end
  end

  assign sarTrial    = sarTrial_ff;
  assign sampling    = (state_ff == sar_adc_seq_pkg::ST_SAMPLE);
  assign busy        = (state_ff != sar_adc_seq_pkg::ST_IDLE);
  assign chanSel     = curChan_ff;
  assign tempSensEn  = tempSensEn_ff;
  assign refSel      = refSel_ff;
  assign extRefEn    = extRefEn_ff;
  assign rangeIrq    = rangeIrq_ff;
  assign scanDone    = scanDone_ff;
  // ========================================================
  // checks
  logic [8:0] convTicks_ff;
  logic [7:0] sampTicks_ff, loadLen_ff;
  logic [2:0] lowestHold_ff;

  // tick counters and held values that only the checks read
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      convTicks_ff  <= 9'h000;
      sampTicks_ff  <= 8'h00;
      loadLen_ff    <= 8'h00;
      lowestHold_ff <= 3'h0;
    end else begin
      lowestHold_ff <= lowestChan;
      if (launch || resultStb || !busy) begin
        convTicks_ff <= 9'h000;
      end else if (adcTick_ff) begin
        convTicks_ff <= convTicks_ff + 9'h001;
      end
      if (!sampling) begin
        sampTicks_ff <= 8'h00;
      end else if (adcTick_ff) begin
        sampTicks_ff <= sampTicks_ff + 8'h01;
      end
      if (launch || resultStb) begin
        loadLen_ff <= sampLen(sampleTime[launch ? launchChan :
                              ((!lastOfScan) ? nxtChan : lowestChan)]);
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  div_tick_a: assert property (adcTick_ff |=> !adcTick_ff [*8])
    else $error("converter tick faster than allowed");
  conv_len_a: assert property (resultStb |-> convTicks_ff >= 9'h011)
    else $error("conversion shorter than 18 ticks");
  scan_chan_a: assert property (
    resultStb && !fwMode |-> chanEnable[curChan_ff])
    else $error("disabled channel converted");
  zero_gap_a: assert property (
    resultStb && !fwMode && !lastOfScan && !lowPower |=> sampling)
    else $error("idle gap between channels");
  fw_chan_a: assert property (
    launch && fwMode && !lowPower |=> chanSel == $past(fwChan))
    else $error("firmware channel not used");
  result_store_a: assert property (
    resultStb |=> result[$past(curChan_ff)] == $past(finalCode) &&
                  resultValid[$past(curChan_ff)])
    else $error("result not stored");
  samp_len_a: assert property (
    sampling && adcTick_ff && sampCnt_ff <= 8'h01 |->
    sampTicks_ff == loadLen_ff - 8'h01)
    else $error("sample length wrong");
  range_irq_a: assert property (resultStb && outRange |=> rangeIrq)
    else $error("out of range not flagged");
  power_idle_a: assert property (lowPower |=> !busy && !adcTick_ff)
    else $error("active in low power");
  scan_wrap_a: assert property (
    resultStb && !fwMode && lastOfScan && scanCont && (|chanEnable) &&
    !lowPower |=> sampling && chanSel == lowestHold_ff)
    else $error("scan did not restart");

endmodule // sar_adc_sequencer_control

// ===== verif/sar_adc_sequencer_control_test.sv
// Purpose: self-checking bench for the sar sequencer control
// Assumes: inputs change on the falling edge of core_clk
// Notes:   compIn is held constant, so every code is 000 or FFF
`include "sar_adc_seq_cfg.svh"
`define CHK(nm, ex, gt) begin numChecks++; if ((gt) !== (ex)) begin \
  badCount++; $display("BAD %s expected %0h seen %0h", nm, ex, gt); end end

module sar_adc_sequencer_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // stimulus and observation
  // starts low with no edge, so the first negedge is a real one
  logic             core_clk = 1'b0;
  logic             resetn, lowPower, fwMode, fwStart;
  logic             scanStart, scanCont, tempOnCh7, rangeClr, compIn;
  logic [2:0]       fwChan, chanSel;
  logic [7:0]       chanEnable, resultClr, resultValid, rangeFlag;
  logic [7:0][7:0]  sampleTime;
  logic [1:0]       refSelect, refSel;
  logic [11:0]      rangeLow, rangeHigh, sarTrial;
  logic             sampling, busy, tempSensEn, extRefEn;
  logic             rangeIrq, scanDone, tempSeen;
  logic [7:0][11:0] result;
  logic [2:0]       order[$];
  int               badCount, numChecks, cycleCount;
  int               nCyc, nSamp, nGap;

  sar_adc_sequencer_control DUT (
    .core_clk(core_clk), .resetn(resetn), .lowPower(lowPower),
    .fwMode(fwMode), .fwStart(fwStart), .fwChan(fwChan),
    .scanStart(scanStart), .scanCont(scanCont),
    .chanEnable(chanEnable), .sampleTime(sampleTime),
    .tempOnCh7(tempOnCh7), .refSelect(refSelect),
    .rangeLow(rangeLow), .rangeHigh(rangeHigh),
    .resultClr(resultClr), .rangeClr(rangeClr), .compIn(compIn),
    .sarTrial(sarTrial), .sampling(sampling), .busy(busy),
    .chanSel(chanSel), .tempSensEn(tempSensEn), .refSel(refSel),
    .extRefEn(extRefEn), .result(result), .resultValid(resultValid),
    .rangeFlag(rangeFlag), .rangeIrq(rangeIrq), .scanDone(scanDone)
  );

  // ==========================================================
  // clock and hang guard: the whole run needs about 2300 cycles
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycleCount++;
    if (cycleCount == 6000) begin
      badCount++;
      results();
    end
  end

  task automatic results();
    if (badCount == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // shared: follow one busy stretch up to the scanDone pulse
  task automatic run();
    int w;
    w = 0;
    nCyc = 0;
    nSamp = 0;
    nGap = 0;
    tempSeen = 1'b0;
    order.delete();
    do begin
      @(negedge core_clk);
      w++;
    end while (busy !== 1'b1 && w < 20);
    order.push_back(chanSel);
    while (scanDone !== 1'b1 && nCyc < 2000) begin
      nSamp += (sampling === 1'b1);
      if (busy !== 1'b1) nGap++;
      if (chanSel === 3'h7 && tempSensEn === 1'b1) tempSeen = 1'b1;
      if (chanSel !== order[$]) order.push_back(chanSel);
      @(negedge core_clk);
      nCyc++;
    end
  endtask

  // one firmware conversion; sample length and total length checked
  task automatic fwConv(input logic [2:0] ch, input logic cmp,
                        input int expCyc, input int expSamp);
    @(negedge core_clk);
    fwMode = 1'b1;
    fwChan = ch;
    compIn = cmp;
    fwStart = 1'b1;
    @(negedge core_clk);
    fwStart = 1'b0;
    run();
    `CHK("chanSel", ch, chanSel)
    `CHK("convCycles", expCyc, nCyc)
    `CHK("sampCycles", expSamp, nSamp)
    `CHK("result", {12{cmp}}, result[ch])
    `CHK("valid", 1'b1, resultValid[ch])
  endtask

  // ==========================================================
  // scenarios
  task automatic refTest();
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      refSelect = i[1:0];
      @(negedge core_clk);
      `CHK("refSel", i[1:0], refSel)
      `CHK("extRefEn", (i[1:0] == `REF_EXT), extRefEn)
    end
  endtask

  // out-of-range flags and request after firmware conversions, then their clears
  task automatic rangeTest();
    rangeLow = 12'h100;
    rangeHigh = 12'hEFF;
    fwConv(3'h1, 1'b0, 162, 54);
    `CHK("irqEarly", 1'b1, rangeIrq)
    fwConv(3'h2, 1'b1, 162, 54);
    `CHK("flags", 8'h06, rangeFlag)
    rangeHigh = 12'hFFF;
    fwConv(3'h3, 1'b1, 162, 54);
    `CHK("inRange", 1'b0, rangeFlag[3])
    @(negedge core_clk);
    rangeClr = 1'b1;
    resultClr = 8'h02;
    @(negedge core_clk);
    rangeClr = 1'b0;
    resultClr = 8'h00;
    @(negedge core_clk);
    `CHK("irqClr", 1'b0, rangeIrq)
    `CHK("flagClr", 8'h04, rangeFlag)
    `CHK("validClr", 1'b0, resultValid[1])
  endtask

  // sparse enable set: three channels back to back, no idle cycles
  task automatic scanTest();
    @(negedge core_clk);
    resultClr = 8'hFF;
    fwMode = 1'b0;
    chanEnable = 8'hA4;
    tempOnCh7 = 1'b1;
    compIn = 1'b1;
    scanStart = 1'b1;
    @(negedge core_clk);
    resultClr = 8'h00;
    scanStart = 1'b0;
    run();
    `CHK("scanCycles", 486, nCyc)
    `CHK("gaps", 0, nGap)
    `CHK("picks", 3, order.size())
    `CHK("order", 9'h0AF, {order[0], order[1], order[2]})
    `CHK("scanValid", 8'hA4, resultValid)
    `CHK("tempSens", 1'b1, tempSeen)
  endtask

  task automatic contTest();
    @(negedge core_clk);
    chanEnable = 8'h0A;
    scanCont = 1'b1;
    scanStart = 1'b1;
    @(negedge core_clk);
    scanStart = 1'b0;
    run();
    `CHK("contOrder", 6'h0B, {order[0], order[1]})
    repeat (2) @(negedge core_clk);
    `CHK("contBusy", 1'b1, busy)
    `CHK("restartCh", 3'h1, chanSel)
    scanCont = 1'b0;
    run();
    repeat (2) @(negedge core_clk);
    `CHK("contStop", 1'b0, busy)
  endtask

  // an aborted conversion leaves no result and no pending work
  task automatic lpTest();
    @(negedge core_clk);
    fwMode = 1'b1;
    fwChan = 3'h6;
    resultClr = 8'hFF;
    fwStart = 1'b1;
    @(negedge core_clk);
    fwStart = 1'b0;
    resultClr = 8'h00;
    repeat (30) @(negedge core_clk);
    lowPower = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("abortBusy", 1'b0, busy)
    fwStart = 1'b1;
    @(negedge core_clk);
    fwStart = 1'b0;
    repeat (20) @(negedge core_clk);
    `CHK("sleepBusy", 1'b0, busy)
    lowPower = 1'b0;
    repeat (200) @(negedge core_clk);
    `CHK("wakeBusy", 1'b0, busy)
    `CHK("abortValid", 1'b0, resultValid[6])
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {resetn, lowPower, fwMode, fwStart, scanStart, scanCont} = '0;
    {tempOnCh7, rangeClr, compIn, fwChan, refSelect} = '0;
    {chanEnable, resultClr, rangeLow} = '0;
    rangeHigh = 12'hFFF;
    sampleTime = {8{8'h03}};
    sampleTime[4] = 8'h0A;
    {badCount, numChecks} = '0;
    repeat (2) @(negedge core_clk);
    `CHK("rstTrial", `SAR_MSB, sarTrial)
    `CHK("rstValid", 8'h00, resultValid)
    resetn = 1'b1;
    refTest();
    fwConv(3'h0, 1'b1, 162, 54);
    fwConv(3'h4, 1'b1, 198, 90);
    rangeTest();
    scanTest();
    contTest();
    lpTest();
    results();
  end
endmodule // sar_adc_sequencer_control_test
